// file: hdl/watchdog_interval_timer.v
/*
 * Watchdog / interval timer: 8-bit up counter on a prescaled tick,
 * timer and reset control/status registers behind guarded word writes,
 * overflow output pulse, chip reset request and interval interrupt.
 * Assumes rst is the synchronised external reset pin and that the bus
 * strobes are one-cycle pulses on clk.
 */
//
// Behaviour
// - reset control register loads 0x1f only on external reset, not on overflow.
// - watchdog flag sets on 0xff to 0x00 wrap in watchdog mode only.
// - watchdog flag clears by read-while-one then write of zero.
// - chip reset enable bit 6 set makes watchdog overflow reset the chip.
// - with enable clear, overflow still resets counter and timer control.
// - reset type bit 5: zero means power-on reset; one is forbidden.
// - reset control bits 4 to 0 always read one, writes ignored.
// - internal chip reset is held for 518 states.
// - external reset beats overflow reset and leaves watchdog flag zero.
// - overflow output lasts 132 states with enable set, else 130.
// - interval overflow sets timer flag and raises interrupt together.
// - registers are written only by word transfers; byte writes ignored.
// - counter and timer control share a write address, key picks target.
// - reset control writes are word transfers to 0xff76.
// - flag-clear form zeroes watchdog flag, keeps enable and type bits.
// - control form loads enable and type bits, keeps watchdog flag.
// - reads: timer control 0xff74, counter 0xff75, reset control 0xff77.
// - counter write wins over a tick in the same cycle.
// - 132 states after overflow writes ignored, flag reads not acknowledged.
// - enable set starts counting; cleared stops and zeroes the counter.
// - mode select zero is interval mode, one is watchdog mode.
// - clock select picks divide by 2 up to 131072 in eight steps.
// - timer flag sets on every interval-mode wrap, clears by read-one then write-zero.
`include "wdog_defines.vh"

module watchdog_interval_timer (
    // Clock and reset (reset is the external reset pin)
    input wire clk,
    input wire rst,
    // Internal register bus
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire bus_word,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    // Reset and overflow outputs
    output wire overflow_output_signal,
    output wire chip_reset_out,
    output reg reset_type_out,
    // Interrupt request
    output reg interval_interrupt
);

    // Counter and timer control/status state
    reg [7:0] timer_count_q;
    reg timer_overflow_flag_q;
    reg timer_mode_select_q;
    reg timer_enable_bit_q;
    reg [2:0] clock_select_q;
    reg timer_flag_armed_q;

    // Reset control/status state
    reg watchdog_overflow_flag_q;
    reg chip_reset_enable_q;
    reg wd_flag_armed_q;

    // Next values
    reg timer_overflow_flag_d;
    reg watchdog_overflow_flag_d;

    // Bus decode
    wire [7:0] wr_key;
    wire [7:0] wr_low;
    wire write_lock;
    wire wr_ok;
    wire wr_shared;
    wire wr_count;
    wire wr_timer_ctrl;
    wire wr_reset_addr;
    wire wr_flag_clear;
    wire wr_reset_ctrl;
    wire rd_timer_ctrl;
    wire rd_reset_ctrl;

    // Counting events
    wire tick;
    wire cnt_step;
    wire wrap;
    wire wd_wrap;
    wire it_wrap;

    // Readback images
    wire [7:0] timer_ctrl_image;
    wire [7:0] reset_ctrl_image;

    // Power-up image of reset control; the stored fields take their reset
    // values from its bits, so the reset value is kept in one place only
    localparam [7:0] RC_RESET = `RESET_CTRL_RESET;

    // Flag update: hardware set wins over a software clear in one cycle
    function next_flag;
        input flag;
        input set;
        input clr;
        begin
            next_flag = set | (flag & ~clr);
        end
    endfunction

    // Guarded write decoding; byte transfers never write
    assign wr_key = bus_wdata[15:8];
    assign wr_low = bus_wdata[7:0];
    assign wr_ok = bus_wr & bus_word & ~write_lock;
    assign wr_shared = wr_ok & (bus_addr == `ADDR_TIMER_CTRL);
    assign wr_count = wr_shared & (wr_key == `KEY_COUNT);
    assign wr_timer_ctrl = wr_shared & (wr_key == `KEY_TIMER_CTRL);
    assign wr_reset_addr = wr_ok & (bus_addr == `ADDR_RESET_CTRL_WR);

    // The clear form only counts when the written flag bit is zero
    assign wr_flag_clear = wr_reset_addr & (wr_key == `KEY_FLAG_CLEAR)
        & ~wr_low[`BIT_WD_FLAG];
    assign wr_reset_ctrl = wr_reset_addr & (wr_key == `KEY_RESET_CTRL);

    // Reads are ordinary byte reads at their own addresses
    assign rd_timer_ctrl = bus_rd & (bus_addr == `ADDR_TIMER_CTRL);
    assign rd_reset_ctrl = bus_rd & (bus_addr == `ADDR_RESET_CTRL_RD);

    // Tick source for the counter. The divider restarts with each enable,
    // so the first period is whole; changing the select while running may
    // cut one period short, which is why software stops the timer first
    wdog_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .run(timer_enable_bit_q),
        .sel(clock_select_q),
        .tick(tick)
    );

    // A counter write in the tick cycle drops that increment
    assign cnt_step = tick & timer_enable_bit_q & ~wr_count;
    assign wrap = cnt_step & (timer_count_q == `COUNT_MAX);
    assign wd_wrap = wrap & timer_mode_select_q;
    assign it_wrap = wrap & ~timer_mode_select_q;

    // Counter. Priority: watchdog wrap, then stop, then write, then tick. A stopped
    // counter ignores writes so that it always reads zero while disabled;
    // a wrap in watchdog mode ends the run and returns it to zero
    always @(posedge clk) begin
        if (rst) begin
            timer_count_q <= `COUNT_RESET;
        end else if (wd_wrap) begin
            timer_count_q <= `COUNT_RESET;
        end else if (!timer_enable_bit_q) begin
            timer_count_q <= `COUNT_RESET;
        end else if (wr_count) begin
            timer_count_q <= wr_low;
        end else if (cnt_step) begin
            timer_count_q <= timer_count_q + 8'h01;
        end
    end

    // Timer flag next value: only a zero write after an armed read clears
    always @* begin
        timer_overflow_flag_d = next_flag(timer_overflow_flag_q, it_wrap,
            wr_timer_ctrl & timer_flag_armed_q & ~wr_low[`BIT_TIMER_FLAG]);
    end

    // Timer control/status fields; a watchdog wrap returns them to reset
    always @(posedge clk) begin
        if (rst || wd_wrap) begin
            timer_overflow_flag_q <= 1'b0;
            timer_mode_select_q <= 1'b0;
            timer_enable_bit_q <= 1'b0;
            clock_select_q <= `CLK_SEL_RESET;
        end else begin
            timer_overflow_flag_q <= timer_overflow_flag_d;
            if (wr_timer_ctrl) begin
                timer_mode_select_q <= wr_low[`BIT_MODE_SEL];
                timer_enable_bit_q <= wr_low[`BIT_TIMER_EN];
                clock_select_q <= wr_low[`CLK_SEL_HI:`CLK_SEL_LO];
            end
        end
    end

    // Arm the timer flag clear on a read that saw it set; a timer control write disarms
    always @(posedge clk) begin
        if (rst || wd_wrap) begin
            timer_flag_armed_q <= 1'b0;
        end else if (wr_timer_ctrl) begin
            timer_flag_armed_q <= 1'b0;
        end else if (rd_timer_ctrl && timer_overflow_flag_q) begin
            timer_flag_armed_q <= 1'b1;
        end
    end

    // Interrupt follows the timer flag in interval mode, same edge as set.
    // The mode is taken from the write in flight so a switch to watchdog
    // mode masks the request at once rather than one cycle late
    always @(posedge clk) begin
        if (rst || wd_wrap) begin
            interval_interrupt <= 1'b0;
        end else begin
            interval_interrupt <= timer_overflow_flag_d
                & ~(wr_timer_ctrl ? wr_low[`BIT_MODE_SEL] : timer_mode_select_q);
        end
    end

    // Watchdog flag next value
    always @* begin
        watchdog_overflow_flag_d = next_flag(watchdog_overflow_flag_q, wd_wrap,
            wr_flag_clear & wd_flag_armed_q);
    end

    // Reset control/status: only the external reset touches it, and it
    // wins over a coincident overflow, so the flag ends at zero
    always @(posedge clk) begin
        if (rst) begin
            watchdog_overflow_flag_q <= RC_RESET[`BIT_WD_FLAG];
            chip_reset_enable_q <= RC_RESET[`BIT_RST_EN];
            reset_type_out <= RC_RESET[`BIT_RST_TYPE];
        end else begin
            watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
            if (wr_reset_ctrl) begin
                chip_reset_enable_q <= wr_low[`BIT_RST_EN];
                reset_type_out <= wr_low[`BIT_RST_TYPE];
            end
        end
    end

    // Reads of the watchdog flag inside the lock window do not arm a clear.
    // Any accepted write to the reset control address disarms, so a stale
    // read can never be paired with a later, unrelated clear
    always @(posedge clk) begin
        if (rst) begin
            wd_flag_armed_q <= 1'b0;
        end else if (wr_reset_addr) begin
            wd_flag_armed_q <= 1'b0;
        end else if (rd_reset_ctrl && watchdog_overflow_flag_q && !write_lock) begin
            wd_flag_armed_q <= 1'b1;
        end
    end

    // Overflow output pulse, its length set by the chip reset enable
    wdog_pulse_timer u_overflow_pulse (
        .clk(clk),
        .rst(rst),
        .start(wd_wrap),
        .load(chip_reset_enable_q ? `PULSE_OUT_LONG : `PULSE_OUT_SHORT),
        .active(overflow_output_signal)
    );

    // Chip-wide power-on reset request, only with the enable bit set
    wdog_pulse_timer u_chip_reset (
        .clk(clk),
        .rst(rst),
        .start(wd_wrap & chip_reset_enable_q),
        .load(`CHIP_RST_CYCLES),
        .active(chip_reset_out)
    );

    // Write lock after a watchdog overflow; software must wait it out.
    // It outlasts the short output pulse by two cycles, so software that
    // polls the pulse alone must still allow that margin
    wdog_pulse_timer u_write_lock (
        .clk(clk),
        .rst(rst),
        .start(wd_wrap),
        .load(`WR_LOCK_CYCLES),
        .active(write_lock)
    );

    // Read images; reserved bits are fixed ones
    assign timer_ctrl_image = {timer_overflow_flag_q, timer_mode_select_q,
        timer_enable_bit_q, `TIMER_CTRL_ONES, clock_select_q};
    assign reset_ctrl_image = {watchdog_overflow_flag_q, chip_reset_enable_q,
        reset_type_out, `RESET_CTRL_ONES};

    // Read data registered one cycle after the strobe; held otherwise.
    // Holding the last value lets a slow reader sample it at leisure
    always @(posedge clk) begin
        if (rst) begin
            bus_rdata <= `READ_UNMAPPED;
        end else if (bus_rd) begin
            case (bus_addr)
                `ADDR_TIMER_CTRL: bus_rdata <= timer_ctrl_image;
                `ADDR_COUNT: bus_rdata <= timer_count_q;
                `ADDR_RESET_CTRL_RD: bus_rdata <= reset_ctrl_image;
                default: bus_rdata <= `READ_UNMAPPED;
            endcase
        end
    end

endmodule

// file: hdl/wdog_defines.vh
/*
 * Constants of the watchdog / interval timer: register addresses, write
 * keys, field positions, reset values and the cycle counts of the
 * overflow pulses.
 * Assumes one system clock state equals one clk cycle.
 */
`ifndef WDOG_DEFINES_VH
`define WDOG_DEFINES_VH

// Register addresses on the internal bus
`define ADDR_TIMER_CTRL 16'hff74
`define ADDR_COUNT 16'hff75
`define ADDR_RESET_CTRL_WR 16'hff76
`define ADDR_RESET_CTRL_RD 16'hff77

// Upper-byte keys of guarded word writes (values of our own choosing)
`define KEY_COUNT 8'h5a
`define KEY_TIMER_CTRL 8'ha5
`define KEY_FLAG_CLEAR 8'ha5
`define KEY_RESET_CTRL 8'h5a

// Field positions of timer_control_status
`define BIT_TIMER_FLAG 7
`define BIT_MODE_SEL 6
`define BIT_TIMER_EN 5
`define CLK_SEL_HI 2
`define CLK_SEL_LO 0

// Field positions of reset_control_status
`define BIT_WD_FLAG 7
`define BIT_RST_EN 6
`define BIT_RST_TYPE 5

// Reset values and read-as-one patterns
`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hff
`define CLK_SEL_RESET 3'h0
`define TIMER_CTRL_ONES 2'h3
`define RESET_CTRL_RESET 8'h1f
`define RESET_CTRL_ONES 5'h1f
`define READ_UNMAPPED 8'h00

// Durations in system clock states
`define CHIP_RST_CYCLES 10'd518
`define PULSE_OUT_LONG 10'd132
`define PULSE_OUT_SHORT 10'd130
`define WR_LOCK_CYCLES 10'd132

// Prescaler: divider width and log2 of each selectable divide ratio
`define PRE_WIDTH 17
`define PRE_SHIFT_0 5'd1
`define PRE_SHIFT_1 5'd6
`define PRE_SHIFT_2 5'd7
`define PRE_SHIFT_3 5'd9
`define PRE_SHIFT_4 5'd11
`define PRE_SHIFT_5 5'd13
`define PRE_SHIFT_6 5'd15
`define PRE_SHIFT_7 5'd17

`endif

// file: hdl/wdog_prescaler.v
/*
 * Counter tick prescaler: divider of the system clock, held at zero while stopped, with
 * eight selectable power-of-two ratios.
 * Assumes run and sel come from registers on the same clock.
 */
`include "wdog_defines.vh"

module wdog_prescaler (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire run,
    input wire [2:0] sel,
    // Tick out, one cycle wide
    output reg tick
);

    reg [`PRE_WIDTH-1:0] div_q;
    wire [`PRE_WIDTH-1:0] mask;

    // Mask of the low divider bits that must all be one for a tick
    function [`PRE_WIDTH-1:0] ratio_mask;
        input [2:0] code;
        reg [4:0] shift;
        begin
            shift = `PRE_SHIFT_0;
            case (code)
                3'h0: shift = `PRE_SHIFT_0;
                3'h1: shift = `PRE_SHIFT_1;
                3'h2: shift = `PRE_SHIFT_2;
                3'h3: shift = `PRE_SHIFT_3;
                3'h4: shift = `PRE_SHIFT_4;
                3'h5: shift = `PRE_SHIFT_5;
                3'h6: shift = `PRE_SHIFT_6;
                default: shift = `PRE_SHIFT_7;
            endcase
            ratio_mask = ~({`PRE_WIDTH{1'b1}} << shift);
        end
    endfunction

    assign mask = ratio_mask(sel);

    // Divider held at zero while stopped so the first period is whole
    always @(posedge clk) begin
        if (rst || !run) begin
            div_q <= {`PRE_WIDTH{1'b0}};
            tick <= 1'b0;
        end else begin
            div_q <= div_q + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
            tick <= ((div_q & mask) == mask);
        end
    end

endmodule

// file: hdl/wdog_pulse_timer.v
/*
 * One-shot pulse timer: on start, its output goes high from the next
 * cycle for exactly load cycles.
 * Assumes start is a one-cycle pulse from logic on the same clock.
 */
module wdog_pulse_timer (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Trigger and length
    input wire start,
    input wire [9:0] load,
    // Pulse out
    output reg active
);

    reg [9:0] cnt_q;

    // A new start restarts the count rather than extending it
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 10'h000;
            active <= 1'b0;
        end else if (start) begin
            cnt_q <= load;
            active <= (load != 10'h000);
        end else begin
            if (cnt_q != 10'h000) begin
                cnt_q <= cnt_q - 10'h001;
            end
            active <= (cnt_q > 10'h001);
        end
    end

endmodule

// file: dv/wdog_monitor.sv
/*
 * Port checker of the watchdog / interval timer.
 * Assumes it is bound to the top module and sees its single clock.
 */
`include "wdog_defines.vh"

module wdog_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_word,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    // Outputs
    input wire logic overflow_output_signal,
    input wire logic chip_reset_out,
    input wire logic reset_type_out,
    input wire logic interval_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] olen_q;
    logic [9:0] clen_q;

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // Run lengths, cleared while low so that a fall sees the whole run
    always @(posedge clk) begin
        olen_q <= (rst || !overflow_output_signal) ? 10'h000 : olen_q + 10'h001;
        clen_q <= (rst || !chip_reset_out) ? 10'h000 : clen_q + 10'h001;
    end

    // Access forms
    sequence rc_rd;
        bus_rd && bus_addr == `ADDR_RESET_CTRL_RD;
    endsequence
    sequence rc_ctl_wr;
        bus_wr && bus_word && bus_addr == `ADDR_RESET_CTRL_WR
            && bus_wdata[15:8] == `KEY_RESET_CTRL;
    endsequence
    // A control write followed, one idle cycle later, by a readback
    sequence rc_ctl_then_rd;
        rc_ctl_wr ##0 unlocked ##1 !bus_wr ##1 rc_rd;
    endsequence
    // The write lock outlasts the short pulse by two cycles
    sequence unlocked;
        !overflow_output_signal && !$past(overflow_output_signal)
            && !$past(overflow_output_signal, 2);
    endsequence

    AST_RST_OUT: assert property ($fell(rst) |->
        !reset_type_out && !chip_reset_out && !overflow_output_signal)
        else $error("outputs not cleared by reset");
    AST_OVERFLOW_LEN: assert property ($fell(overflow_output_signal) |->
        olen_q == (chip_reset_out ? 10'd132 : 10'd130)) else $error("overflow pulse length");
    AST_CHR_LEN: assert property ($fell(chip_reset_out) |-> clen_q == 10'd518)
        else $error("chip reset length");
    AST_CHR_START: assert property ($rose(chip_reset_out) |->
        $rose(overflow_output_signal)) else $error("chip reset without overflow");
    AST_INT_FLAG: assert property (bus_rd && bus_addr == `ADDR_TIMER_CTRL
        && interval_interrupt |=> bus_rdata[7]) else $error("interrupt without flag");
    AST_LOCK: assert property (overflow_output_signal |=> $stable(reset_type_out))
        else $error("write taken during lock");
    AST_RC_TYPE_WR: assert property (rc_ctl_wr ##0 unlocked |=>
        reset_type_out == $past(bus_wdata[5])) else $error("reset type not loaded");
    AST_RC_EN_WR: assert property (rc_ctl_then_rd |=>
        bus_rdata[6] == $past(bus_wdata[6], 3)) else $error("chip reset enable not loaded");
    AST_BYTE_WR: assert property (bus_wr && !bus_word |=> $stable(reset_type_out))
        else $error("byte write taken");
    AST_RC_ONES: assert property (rc_rd |=> bus_rdata[4:0] == 5'h1f)
        else $error("reset control low bits");
    AST_UNMAPPED: assert property (bus_rd && bus_addr == `ADDR_RESET_CTRL_WR |=>
        bus_rdata == `READ_UNMAPPED) else $error("unmapped read data");
endmodule

// file: dv/test_watchdog_interval_timer.sv
/*
 * Self-checking bench of the watchdog / interval timer.
 * Assumes the checker file is compiled before this one.
 */
`include "wdog_defines.vh"

module test_watchdog_interval_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_word = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    wire [7:0] bus_rdata;
    wire overflow_output_signal;
    wire chip_reset_out;
    wire reset_type_out;
    wire interval_interrupt;
    int err_count = 0;
    int checks = 0;
    logic [15:0] pulse_t = 16'h0000;
    logic [7:0] exp_q[$];
    logic [15:0] chr_t = 16'h0000;
    logic [7:0] rc_m;
    logic [7:0] v;

    always #12.5 clk = ~clk;

    watchdog_interval_timer dut_u (
        .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_word(bus_word), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .overflow_output_signal(overflow_output_signal), .chip_reset_out(chip_reset_out),
        .reset_type_out(reset_type_out), .interval_interrupt(interval_interrupt)
    );

    // High-time totals of both pulses, so one total covers length and absence
    always @(posedge clk) begin
        if (!rst) begin
            pulse_t <= pulse_t + 16'(overflow_output_signal);
            chr_t <= chr_t + 16'(chip_reset_out);
        end
    end

    task chk(input logic [15:0] s, input logic [15:0] e, input string n);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(posedge clk);
        #2;
        bus_addr = a;
        bus_wdata = d;
        bus_word = w;
        bus_wr = 1'b1;
        @(posedge clk);
        #2;
        bus_wr = 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk);
        #2;
        bus_rd = 1'b0;
        chk(16'(bus_rdata), 16'(e), "bus_rdata");
    endtask

    // Bounded wait for the interrupt (w high) or the overflow pulse
    task wt(input logic w);
        int i;
        i = 0;
        while ((w ? interval_interrupt : overflow_output_signal) !== 1'b1 && i < 200) begin
            @(posedge clk);
            #2;
            i++;
        end
        chk(16'(i < 200), 16'h0001, "wait");
    endtask

    task close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h8d38a354));
        repeat (5) @(posedge clk);
        #2;
        rst = 1'b0;
        rc_m = 8'h1f;
        rd(16'hff74, 8'h18);
        rd(16'hff75, 8'h00);
        rd(16'hff77, rc_m);
        rd(16'hff76, 8'h00);
        // Control form; low five bits read as ones whatever is written, and
        // the reset type stays at power-on reset since one is forbidden
        wr(16'hff76, {`KEY_RESET_CTRL, 8'h40});
        rd(16'hff77, 8'h5f);
        chk(16'(reset_type_out), 16'h0000, "reset_type_out");
        rc_m = 8'h5f;
        // Byte writes that would clear the enable or start the timer are ignored
        wr(16'hff76, {`KEY_RESET_CTRL, 8'h00}, 1'b0);
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h60}, 1'b0);
        rd(16'hff77, rc_m);
        rd(16'hff74, 8'h18);
        // Watchdog wraps, chip reset enabled first and then disabled
        // The write inside the lock tries to flip the enable bit
        for (int k = 0; k < 2; k++) begin
            wr(16'hff74, {`KEY_TIMER_CTRL, 8'h60});
            wr(16'hff74, {`KEY_COUNT, 8'hf0});
            wt(1'b0);
            wr(16'hff76, {`KEY_RESET_CTRL, k ? 8'h40 : 8'h00});
            repeat (600) @(posedge clk);
            #2;
            chk(pulse_t, k ? 16'd262 : 16'd132, "pulse_time");
            chk(chr_t, 16'd518, "chr_time");
            rd(16'hff77, rc_m | 8'h80);
            rd(16'hff74, 8'h18);
            rd(16'hff75, 8'h00);
            wr(16'hff76, {`KEY_FLAG_CLEAR, 8'h00});
            rd(16'hff77, rc_m);
            wr(16'hff76, {`KEY_RESET_CTRL, 8'h00});
            rc_m = 8'h1f;
        end
        // Regular counter rewrites keep the watchdog from overflowing
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h60});
        repeat (4) begin
            repeat (100) @(posedge clk);
            wr(16'hff74, {`KEY_COUNT, 8'h00});
        end
        chk(pulse_t, 16'd262, "pulse_time");
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h00});
        // Interval mode; the counter keeps running after the wrap
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h20});
        wr(16'hff74, {`KEY_COUNT, 8'hfe});
        wt(1'b1);
        rd(16'hff74, 8'hb8);
        rd(16'hff77, 8'h1f);
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h20});
        rd(16'hff74, 8'h38);
        chk(16'(interval_interrupt), 16'h0000, "interval_interrupt");
        // Stop before the clock select changes, then random loads on a slow tick
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h00});
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h27});
        repeat (4) begin
            v = 8'($urandom);
            exp_q.push_back(v);
            wr(16'hff74, {`KEY_COUNT, v});
            rd(16'hff75, exp_q.pop_front());
        end
        wr(16'hff74, {`KEY_TIMER_CTRL, 8'h07});
        rd(16'hff75, 8'h00);
        // External reset reloads the reset control register
        wr(16'hff76, {`KEY_RESET_CTRL, 8'h40});
        @(posedge clk);
        #2;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        rd(16'hff77, 8'h1f);
        rd(16'hff74, 8'h18);
        close_out;
    end

    // Hang guard, well beyond the few thousand cycles the tests need
    initial begin
        #(25 * 20000);
        err_count++;
        close_out;
    end
endmodule

bind watchdog_interval_timer wdog_monitor mon_u (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_word(bus_word), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .overflow_output_signal(overflow_output_signal), .chip_reset_out(chip_reset_out),
    .reset_type_out(reset_type_out), .interval_interrupt(interval_interrupt)
);
